// File: core/nfc_ctrl.sv
// nvm flash/eeprom controller: arrays, read arbitration, command sequencer, apb registers
`timescale 1ns/1ps
`default_nettype none
module nfc_ctrl #(
  parameter bit FLASH_64K = 1'b1 // 1: 64 KB variant, 0: 32 KB
) (
  input wire logic ref_clk, // bus clock
  input wire logic nrst, // sync reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic rd_req, // cpu array read request
  input wire nfc_pkg::nfc_rd_req_t rd_cmd, // array select and address
  output logic rd_ready, // read taken this edge
  output var nfc_pkg::nfc_rd_rsp_t rd_data, // read byte and ecc flags
  input wire logic stop_req, // stop mode request
  output logic stop_ack, // stop may be entered
  output logic cmd_irq, // command complete interrupt
  output logic err_irq // error interrupt
);
  typedef enum logic [5:0] {
    ST_HOLD = 6'b000001,
    ST_LOAD = 6'b000010,
    ST_IDLE = 6'b000100,
    ST_CHECK = 6'b001000,
    ST_WAIT = 6'b010000,
    ST_WRITE = 6'b100000
  } nfc_st_t;

  logic [7:0] flash_mem [0:nfc_pkg::FL_BYTES-1];
  logic [21:0] ee_mem [0:nfc_pkg::EE_WORDS-1];
  nfc_st_t st_r;
  logic [15:0] cnt_r, ptr_r, base_r, last_r;
  logic [5:0] fdiv_r, div_cnt_r;
  logic fdivld_r, ccie_r, errie_r, cmd_complete_flag_r, access_error_flag_r, pviol_r, sfd_r, dfd_r;
  logic tgt_ee_r, erase_r;
  logic [1:0] verify_status_field_r;
  logic [2:0] ccobix_r;
  logic [5:0][15:0] ccob_r;
  logic [7:0] flash_protect_reg_r, eeprom_protect_reg_r, nvm_option_reg_r, security_reg_r;
  nfc_pkg::nfc_rd_rsp_t rd_data_r;
  logic [31:0] prdata_r;
  logic wr_en, launch, tick, fl_busy, ee_busy, rd_acc, last_hit, secured;
  logic c_bad, c_pv, c_ee, c_erase;
  logic [15:0] c_base, c_last, c_ticks, off;
  logic [7:0] fl_rd_byte, wbyte, ee_old, ee_new;
  logic [15:0] fl_word;
  logic [2:0] ee_ix;
  nfc_pkg::nfc_ecc_res_t ee_rd, ee_cfg, ee_rmw;

  // flash address usable for program and sector erase
  // reserved and gap sectors refused, and the low FL_PART_SKIP bytes of the partial sector
  function automatic logic fl_avail(input logic [15:0] a);
    logic [6:0] s;
    s = a[15:9];
    if (FLASH_64K) begin
      return !(s <= nfc_pkg::FL_RSVD_LAST || s == nfc_pkg::FL_GAP_SECT ||
               (s == nfc_pkg::FL_PART_SECT && a[8:0] < nfc_pkg::FL_PART_SKIP));
    end
    return a >= nfc_pkg::FL32_BASE;
  endfunction

  // apb strobes, zero wait state slave
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign launch = wr_en && paddr == nfc_pkg::REG_STAT && pwdata[nfc_pkg::STAT_CMD_COMPLETE_FLAG] && cmd_complete_flag_r &&
                  !access_error_flag_r && !pviol_r && st_r == ST_IDLE;
  assign secured = security_reg_r[1:0] != nfc_pkg::SEC_UNSEC;
  assign tick = div_cnt_r == fdiv_r;
  assign last_hit = ptr_r == last_r;

  // unmapped address answers with an error
  always_comb begin
    unique case (paddr)
      nfc_pkg::REG_DIV, nfc_pkg::REG_CFG, nfc_pkg::REG_STAT, nfc_pkg::REG_IX, nfc_pkg::REG_CCOB,
      nfc_pkg::REG_FLASH_PROTECT_REG, nfc_pkg::REG_EEPROM_PROTECT_REG, nfc_pkg::REG_NVM_OPTION_REG, nfc_pkg::REG_SECURITY_REG,
      nfc_pkg::REG_ERR: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // flash busy for flash commands, and in the check cycle of any command
  assign fl_busy = st_r == ST_CHECK || ((st_r == ST_WAIT || st_r == ST_WRITE) && !tgt_ee_r);
  assign ee_busy = st_r == ST_CHECK || ((st_r == ST_WAIT || st_r == ST_WRITE) && tgt_ee_r);
  // eeprom waits on any flash command
  // all reads held during early init
  assign rd_ready = st_r != ST_HOLD && (rd_cmd.ee ? !(fl_busy || ee_busy) : !fl_busy);
  assign rd_acc = rd_req && rd_ready;
  assign fl_rd_byte = flash_mem[rd_cmd.addr];
  assign ee_rd = nfc_pkg::nfc_ecc_dec(ee_mem[rd_cmd.addr[7:1]]);
  assign ee_cfg = nfc_pkg::nfc_ecc_dec(ee_mem[nfc_pkg::EE_CFG_WORD]);
  assign rd_data = rd_data_r;

  // stop granted only when idle and complete
  assign stop_ack = stop_req && cmd_complete_flag_r && st_r == ST_IDLE;
  // completion irq usable as wake source
  assign cmd_irq = ccie_r && cmd_complete_flag_r;
  assign err_irq = errie_r && dfd_r;

  // read byte registered at the taking edge
  // ecc checked and corrected on eeprom reads
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_data_r <= '0;
    end else if (rd_acc) begin
      rd_data_r.data <= rd_cmd.ee ? (rd_cmd.addr[0] ? ee_rd.data[7:0] : ee_rd.data[15:8]) : fl_rd_byte;
      rd_data_r.sgl <= rd_cmd.ee && ee_rd.sgl;
      rd_data_r.dbl <= rd_cmd.ee && ee_rd.dbl;
    end
  end

  // command decode and validation
  always_comb begin
    c_bad = 1'b1;
    c_ee = 1'b0;
    c_erase = 1'b0;
    c_base = '0;
    c_last = '0;
    c_ticks = 16'(nfc_pkg::PGM_TICKS);
    case (ccob_r[0][15:8])
      nfc_pkg::CMD_PGM_FL: begin
        c_base = ccob_r[1] & ~nfc_pkg::PGM_MASK;
        c_last = c_base | nfc_pkg::PGM_MASK;
        c_bad = ccobix_r != nfc_pkg::IX_D1 || !fl_avail(c_base) || secured;
      end
      nfc_pkg::CMD_ERS_SECT: begin
        c_erase = 1'b1;
        c_base = ccob_r[1] & ~nfc_pkg::SECT_MASK;
        c_last = c_base | nfc_pkg::SECT_MASK;
        c_ticks = 16'(nfc_pkg::ERS_TICKS);
        c_bad = !fl_avail(c_base) || secured;
      end
      // small variant block begins at its base
      nfc_pkg::CMD_ERS_BLK: begin
        c_erase = 1'b1;
        c_base = FLASH_64K ? '0 : nfc_pkg::FL32_BASE;
        c_last = nfc_pkg::FL_LAST;
        c_ticks = 16'(nfc_pkg::ERS_TICKS);
        c_bad = 1'b0;
      end
      // burst of one to four bytes
      nfc_pkg::CMD_PGM_EE: begin
        c_ee = 1'b1;
        c_base = {8'h00, ccob_r[1][7:0]};
        c_last = c_base + 16'(ccobix_r) - 16'(nfc_pkg::IX_D0);
        c_bad = ccobix_r < nfc_pkg::IX_D0 || ccobix_r > nfc_pkg::IX_LAST ||
                ccob_r[1][15:8] != 8'h00 || c_last[15:8] != 8'h00;
      end
      nfc_pkg::CMD_ERS_EE: begin
        c_ee = 1'b1;
        c_erase = 1'b1;
        c_base = {8'h00, ccob_r[1][7:0]} & ~nfc_pkg::EE_SECT_MASK;
        c_last = c_base | nfc_pkg::EE_SECT_MASK;
        c_ticks = 16'(nfc_pkg::ERS_TICKS);
        c_bad = ccob_r[1][15:8] != 8'h00;
      end
      default: c_bad = 1'b1;
    endcase
    if (!fdivld_r) c_bad = 1'b1;
    c_pv = !c_bad && (c_ee ? !eeprom_protect_reg_r[nfc_pkg::PROT_OPEN] : !flash_protect_reg_r[nfc_pkg::PROT_OPEN]);
  end

  // sequencer state
  // reset returns to init, aborting any command
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r <= ST_HOLD;
    end else begin
      unique case (st_r)
        ST_HOLD: if (cnt_r == '0) st_r <= ST_LOAD;
        ST_LOAD: if (cnt_r == '0) st_r <= ST_IDLE;
        ST_IDLE: if (launch) st_r <= ST_CHECK;
        ST_CHECK: st_r <= (c_bad || c_pv) ? ST_IDLE : ST_WAIT;
        ST_WAIT: if (tick && cnt_r == '0) st_r <= ST_WRITE;
        ST_WRITE: if (last_hit) st_r <= ST_IDLE;
      endcase
    end
  end

  // init and program/erase time counter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_r <= 16'(nfc_pkg::INIT_HOLD_CYC - 1);
    end else if (st_r == ST_HOLD) begin
      cnt_r <= (cnt_r == '0) ? 16'(nfc_pkg::INIT_LOAD_CYC - 1) : cnt_r - 16'h0001;
    end else if (st_r == ST_LOAD && cnt_r != '0) begin
      cnt_r <= cnt_r - 16'h0001;
    end else if (st_r == ST_CHECK) begin
      cnt_r <= c_ticks - 16'h0001;
    end else if (st_r == ST_WAIT && tick && cnt_r != '0) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // program/erase clock divider
  always_ff @(posedge ref_clk) begin
    if (!nrst || st_r == ST_CHECK) div_cnt_r <= '0;
    else div_cnt_r <= tick ? '0 : div_cnt_r + 6'h01;
  end

  // target latch and write pointer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tgt_ee_r <= 1'b0;
      erase_r <= 1'b0;
      base_r <= '0;
      last_r <= '0;
      ptr_r <= '0;
    end else if (st_r == ST_CHECK) begin
      tgt_ee_r <= c_ee;
      erase_r <= c_erase;
      base_r <= c_base;
      last_r <= c_last;
      ptr_r <= c_base;
    end else if (st_r == ST_WRITE && !last_hit) begin
      ptr_r <= ptr_r + 16'h0001;
    end
  end

  // data byte for the current write step
  assign off = ptr_r - base_r;
  localparam int unsigned IX_D0_I = nfc_pkg::IX_D0;
  localparam int unsigned IX_D1_I = nfc_pkg::IX_D1;
  assign fl_word = off[1] ? ccob_r[IX_D1_I] : ccob_r[IX_D0_I];
  assign ee_ix = {1'b0, off[1:0]} + nfc_pkg::IX_D0;
  assign wbyte = tgt_ee_r ? ccob_r[ee_ix][7:0] : (off[0] ? fl_word[7:0] : fl_word[15:8]);
  assign ee_rmw = nfc_pkg::nfc_ecc_dec(ee_mem[ptr_r[7:1]]);
  assign ee_old = ptr_r[0] ? ee_rmw.data[7:0] : ee_rmw.data[15:8];
  // erase sets all ones, program clears bits
  assign ee_new = erase_r ? nfc_pkg::ERASED_BYTE : (ee_old & wbyte);

  // flash array writes
  always_ff @(posedge ref_clk) begin
    if (st_r == ST_WRITE && !tgt_ee_r) begin
      flash_mem[ptr_r] <= erase_r ? nfc_pkg::ERASED_BYTE : (flash_mem[ptr_r] & wbyte);
    end
  end

  // eeprom read-modify-write with fresh parity
  always_ff @(posedge ref_clk) begin
    if (st_r == ST_WRITE && tgt_ee_r) begin
      ee_mem[ptr_r[7:1]] <= nfc_pkg::nfc_ecc_enc(ptr_r[0] ? {ee_rmw.data[15:8], ee_new} :
                                                            {ee_new, ee_rmw.data[7:0]});
    end
  end

  // settings loaded at the end of init
  // fault falls back to locked defaults
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flash_protect_reg_r <= nfc_pkg::DEF_FLASH_PROTECT_REG;
      eeprom_protect_reg_r <= nfc_pkg::DEF_EEPROM_PROTECT_REG;
      nvm_option_reg_r <= nfc_pkg::DEF_NVM_OPTION_REG;
      security_reg_r <= nfc_pkg::DEF_SECURITY_REG;
      verify_status_field_r <= '0;
    end else if (st_r == ST_LOAD && cnt_r == '0) begin
      flash_protect_reg_r <= ee_cfg.dbl ? nfc_pkg::DEF_FLASH_PROTECT_REG : flash_mem[nfc_pkg::CFG_FLASH_PROTECT_REG_ADDR];
      eeprom_protect_reg_r <= ee_cfg.dbl ? nfc_pkg::DEF_EEPROM_PROTECT_REG : flash_mem[nfc_pkg::CFG_EEPROM_PROTECT_REG_ADDR];
      nvm_option_reg_r <= ee_cfg.dbl ? nfc_pkg::DEF_NVM_OPTION_REG : flash_mem[nfc_pkg::CFG_NVM_OPTION_REG_ADDR];
      security_reg_r <= ee_cfg.dbl ? nfc_pkg::DEF_SECURITY_REG : flash_mem[nfc_pkg::CFG_SECURITY_REG_ADDR];
      verify_status_field_r <= ee_cfg.dbl ? nfc_pkg::VERIFY_STATUS_FIELD_DBL : 2'b00;
    end else if (launch) begin
      verify_status_field_r <= '0;
    end
  end

  // completion flag
  // launch clears it, completion sets it
  always_ff @(posedge ref_clk) begin
    if (!nrst) cmd_complete_flag_r <= 1'b0;
    else if (st_r == ST_LOAD && cnt_r == '0) cmd_complete_flag_r <= 1'b1;
    else if (launch) cmd_complete_flag_r <= 1'b0;
    else if (st_r == ST_CHECK && (c_bad || c_pv)) cmd_complete_flag_r <= 1'b1;
    else if (st_r == ST_WRITE && last_hit) cmd_complete_flag_r <= 1'b1;
  end

  // access and protection errors, set beats clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      access_error_flag_r <= 1'b0;
      pviol_r <= 1'b0;
    end else begin
      access_error_flag_r <= (st_r == ST_CHECK && c_bad) ||
                  (access_error_flag_r && !(wr_en && paddr == nfc_pkg::REG_STAT && pwdata[nfc_pkg::STAT_ACCESS_ERROR_FLAG]));
      pviol_r <= (st_r == ST_CHECK && c_pv) ||
                 (pviol_r && !(wr_en && paddr == nfc_pkg::REG_STAT && pwdata[nfc_pkg::STAT_PVIOL]));
    end
  end

  // ecc fault flags from cpu reads, set beats clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sfd_r <= 1'b0;
      dfd_r <= 1'b0;
    end else begin
      sfd_r <= (rd_acc && rd_cmd.ee && ee_rd.sgl) ||
               (sfd_r && !(wr_en && paddr == nfc_pkg::REG_ERR && pwdata[nfc_pkg::ERR_SFD]));
      dfd_r <= (rd_acc && rd_cmd.ee && ee_rd.dbl) ||
               (dfd_r && !(wr_en && paddr == nfc_pkg::REG_ERR && pwdata[nfc_pkg::ERR_DFD]));
    end
  end

  // divider, config, index and command object writes
  // object and index locked while flag clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fdiv_r <= '0;
      fdivld_r <= 1'b0;
      ccie_r <= 1'b0;
      errie_r <= 1'b0;
      ccobix_r <= '0;
      ccob_r <= '0;
    end else if (wr_en) begin
      if (paddr == nfc_pkg::REG_DIV && cmd_complete_flag_r) begin
        fdiv_r <= pwdata[5:0];
        fdivld_r <= 1'b1;
      end
      if (paddr == nfc_pkg::REG_CFG) begin
        ccie_r <= pwdata[nfc_pkg::CFG_CCIE];
        errie_r <= pwdata[nfc_pkg::CFG_ERRIE];
      end
      if (paddr == nfc_pkg::REG_IX && cmd_complete_flag_r) ccobix_r <= pwdata[2:0];
      if (paddr == nfc_pkg::REG_CCOB && cmd_complete_flag_r && ccobix_r <= nfc_pkg::IX_LAST) begin
        ccob_r[ccobix_r] <= pwdata[15:0];
      end
    end
  end

  // read mux, captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      prdata_r <= '0;
      case (paddr)
        nfc_pkg::REG_DIV: prdata_r <= 32'({fdivld_r, 1'b0, fdiv_r});
        nfc_pkg::REG_CFG: begin
          prdata_r[nfc_pkg::CFG_CCIE] <= ccie_r;
          prdata_r[nfc_pkg::CFG_ERRIE] <= errie_r;
        end
        nfc_pkg::REG_STAT: begin
          prdata_r[nfc_pkg::STAT_CMD_COMPLETE_FLAG] <= cmd_complete_flag_r;
          prdata_r[nfc_pkg::STAT_ACCESS_ERROR_FLAG] <= access_error_flag_r;
          prdata_r[nfc_pkg::STAT_PVIOL] <= pviol_r;
          prdata_r[1:0] <= verify_status_field_r;
        end
        nfc_pkg::REG_IX: prdata_r[2:0] <= ccobix_r;
        nfc_pkg::REG_CCOB: if (ccobix_r <= nfc_pkg::IX_LAST) prdata_r[15:0] <= ccob_r[ccobix_r];
        nfc_pkg::REG_FLASH_PROTECT_REG: prdata_r[7:0] <= flash_protect_reg_r;
        nfc_pkg::REG_EEPROM_PROTECT_REG: prdata_r[7:0] <= eeprom_protect_reg_r;
        nfc_pkg::REG_NVM_OPTION_REG: prdata_r[7:0] <= nvm_option_reg_r;
        nfc_pkg::REG_SECURITY_REG: prdata_r[7:0] <= security_reg_r;
        nfc_pkg::REG_ERR: begin
          prdata_r[nfc_pkg::ERR_DFD] <= dfd_r;
          prdata_r[nfc_pkg::ERR_SFD] <= sfd_r;
        end
        default: prdata_r <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence launch_s;
    launch;
  endsequence
  sequence check_s;
    !cmd_complete_flag_r && st_r == ST_CHECK;
  endsequence
  launch_clear_a: assert property (launch_s |=> check_s)
    else $error("launch did not clear flag");
  fl_read_a: assert property (rd_acc && !rd_cmd.ee |=> rd_data_r.data == $past(fl_rd_byte))
    else $error("flash byte not returned next cycle");
  ee_hold_a: assert property (rd_req && rd_cmd.ee && fl_busy |-> !rd_ready)
    else $error("eeprom read during flash command");
  fl_serve_a: assert property (st_r == ST_WAIT && tgt_ee_r && !rd_cmd.ee |-> rd_ready)
    else $error("flash read stalled by eeprom command");
  ee_ecc_a: assert property (rd_acc && rd_cmd.ee && ee_rd.dbl |=> rd_data_r.dbl && dfd_r)
    else $error("double fault not flagged");
  erase_ones_a: assert property (st_r == ST_WRITE && !tgt_ee_r && erase_r |=>
    flash_mem[$past(ptr_r)] == nfc_pkg::ERASED_BYTE)
    else $error("erased byte not all ones");
  ccob_lock_a: assert property (!cmd_complete_flag_r |=> $stable(ccob_r))
    else $error("object changed while busy");
  stop_gate_a: assert property (!cmd_complete_flag_r |-> !stop_ack)
    else $error("stop granted during command");
  div_err_a: assert property (st_r == ST_CHECK && !fdivld_r |=> access_error_flag_r && cmd_complete_flag_r && st_r == ST_IDLE)
    else $error("command ran without divider");
  init_flag_a: assert property ($fell(st_r == ST_HOLD) |-> !cmd_complete_flag_r ##[1:40] cmd_complete_flag_r)
    else $error("init completion flag not set in time");
  init_dbl_a: assert property (st_r == ST_LOAD && cnt_r == '0 && ee_cfg.dbl |=>
    verify_status_field_r == nfc_pkg::VERIFY_STATUS_FIELD_DBL && security_reg_r == nfc_pkg::DEF_SECURITY_REG)
    else $error("init fault not reported");
endmodule
`default_nettype wire

// File: core/nfc_pkg.sv
// constants, types and ecc helpers for the nvm flash/eeprom controller
package nfc_pkg;
  // timing
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned INIT_HOLD_NS = 500;
  localparam int unsigned INIT_HOLD_CYC = (INIT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned INIT_LOAD_NS = 300;
  localparam int unsigned INIT_LOAD_CYC = (INIT_LOAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FCLK_MHZ = 1;
  localparam int unsigned PGM_TIME_US = 20;
  localparam int unsigned ERS_TIME_US = 100;
  localparam int unsigned PGM_TICKS = PGM_TIME_US * FCLK_MHZ;
  localparam int unsigned ERS_TICKS = ERS_TIME_US * FCLK_MHZ;
  // arrays and map
  localparam int unsigned FL_BYTES = 65536;
  localparam int unsigned EE_WORDS = 128;
  localparam int unsigned FL_PART_AVAIL = 448;
  localparam int unsigned SECT_BYTES = 512;
  localparam logic [8:0] FL_PART_SKIP = 9'(SECT_BYTES - FL_PART_AVAIL);
  localparam logic [6:0] FL_RSVD_LAST = 7'h07;
  localparam logic [6:0] FL_PART_SECT = 7'h08;
  localparam logic [6:0] FL_GAP_SECT = 7'h18;
  localparam logic [15:0] FL32_BASE = 16'h8000;
  localparam logic [15:0] FL_LAST = 16'hffff;
  localparam logic [15:0] SECT_MASK = 16'h01ff;
  localparam logic [15:0] PGM_MASK = 16'h0003;
  localparam logic [15:0] EE_SECT_MASK = 16'h0001;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // configuration image
  localparam logic [15:0] CFG_FLASH_PROTECT_REG_ADDR = 16'hff7c;
  localparam logic [15:0] CFG_EEPROM_PROTECT_REG_ADDR = 16'hff7d;
  localparam logic [15:0] CFG_NVM_OPTION_REG_ADDR = 16'hff7e;
  localparam logic [15:0] CFG_SECURITY_REG_ADDR = 16'hff7f;
  localparam logic [6:0] EE_CFG_WORD = 7'h7f;
  localparam logic [7:0] DEF_FLASH_PROTECT_REG = 8'h00;
  localparam logic [7:0] DEF_EEPROM_PROTECT_REG = 8'h00;
  localparam logic [7:0] DEF_NVM_OPTION_REG = 8'h00;
  localparam logic [7:0] DEF_SECURITY_REG = 8'h00;
  localparam int unsigned PROT_OPEN = 7;
  localparam logic [1:0] SEC_UNSEC = 2'b10;
  localparam logic [1:0] VERIFY_STATUS_FIELD_DBL = 2'b11;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_DIV = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_IX = 8'h0c;
  localparam logic [7:0] REG_CCOB = 8'h10;
  localparam logic [7:0] REG_FLASH_PROTECT_REG = 8'h14;
  localparam logic [7:0] REG_EEPROM_PROTECT_REG = 8'h18;
  localparam logic [7:0] REG_NVM_OPTION_REG = 8'h1c;
  localparam logic [7:0] REG_SECURITY_REG = 8'h20;
  localparam logic [7:0] REG_ERR = 8'h24;
  // field positions
  localparam int unsigned DIV_LD = 7;
  localparam int unsigned CFG_CCIE = 7;
  localparam int unsigned CFG_ERRIE = 0;
  localparam int unsigned STAT_CMD_COMPLETE_FLAG = 7;
  localparam int unsigned STAT_ACCESS_ERROR_FLAG = 5;
  localparam int unsigned STAT_PVIOL = 4;
  localparam int unsigned ERR_DFD = 1;
  localparam int unsigned ERR_SFD = 0;
  // command codes and object indices
  localparam logic [7:0] CMD_PGM_FL = 8'h06;
  localparam logic [7:0] CMD_ERS_BLK = 8'h09;
  localparam logic [7:0] CMD_ERS_SECT = 8'h0a;
  localparam logic [7:0] CMD_PGM_EE = 8'h11;
  localparam logic [7:0] CMD_ERS_EE = 8'h12;
  localparam logic [2:0] IX_D0 = 3'h2;
  localparam logic [2:0] IX_D1 = 3'h3;
  localparam logic [2:0] IX_LAST = 3'h5;

  typedef struct packed {logic ee; logic [15:0] addr;} nfc_rd_req_t;
  typedef struct packed {logic [7:0] data; logic sgl; logic dbl;} nfc_rd_rsp_t;
  typedef struct packed {logic [15:0] data; logic sgl; logic dbl;} nfc_ecc_res_t;

  // secded encode: hamming bits at positions 1..21, overall parity at 0
  function automatic logic [21:0] nfc_ecc_enc(input logic [15:0] d);
    logic [21:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < 22; p++) if ((p & (p - 1)) != 0) begin
      c[p] = d[k];
      k++;
    end
    for (int b = 0; b < 5; b++) for (int p = 1; p < 22; p++) if (p[b] && p != (1 << b)) c[1 << b] ^= c[p];
    c[0] = ^c[21:1];
    return c;
  endfunction

  // secded decode with single-bit correction
  function automatic nfc_ecc_res_t nfc_ecc_dec(input logic [21:0] cw);
    logic [21:0] c;
    logic [4:0] syn;
    nfc_ecc_res_t r;
    int k;
    c = cw;
    syn = '0;
    r = '0;
    k = 0;
    for (int p = 1; p < 22; p++) if (c[p]) syn ^= p[4:0];
    if (syn != '0 && (^c) && syn < 5'd22) begin
      c[syn] = ~c[syn];
      r.sgl = 1'b1;
    end else if (syn != '0) r.dbl = 1'b1;
    else if (^c) r.sgl = 1'b1;
    for (int p = 1; p < 22; p++) if ((p & (p - 1)) != 0) begin
      r.data[k] = c[p];
      k++;
    end
    return r;
  endfunction
endpackage

// File: tb/nfc_cpu_model.sv
// cpu side model issuing array reads
`timescale 1ns/1ps
`default_nettype none
module nfc_cpu_model (
  input wire logic ref_clk, // bus clock
  input wire logic go, // keep requesting
  input wire logic rd_ready, // read taken
  input wire nfc_pkg::nfc_rd_req_t want, // array and address to read
  output logic rd_req, // read request
  output var nfc_pkg::nfc_rd_req_t rd_cmd, // array and byte address
  output logic got // a read was taken
);
  always_ff @(posedge ref_clk) begin
    rd_req <= go;
    rd_cmd <= want;
    got <= go & (got | (rd_req & rd_ready));
  end
endmodule
`default_nettype wire

// File: tb/test_nvm_flash_eeprom_controller.sv
// self-checking bench for the nvm controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module test_nvm_flash_eeprom_controller;
  logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, rd_req, rd_ready, stop_req = 1'b0, stop_ack, cmd_irq, err_irq, go = 1'b0, got;
  nfc_pkg::nfc_rd_req_t rd_cmd;
  nfc_pkg::nfc_rd_req_t want = 17'h02000;
  nfc_pkg::nfc_rd_rsp_t rd_data;
  int fail_count = 0, total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  nfc_ctrl #(.FLASH_64K(1'b1)) DUT (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_ready(rd_ready), .rd_data(rd_data),
    .stop_req(stop_req), .stop_ack(stop_ack), .cmd_irq(cmd_irq), .err_irq(err_irq));
  nfc_cpu_model cpu (.ref_clk(ref_clk), .go(go), .rd_ready(rd_ready), .want(want), .rd_req(rd_req),
    .rd_cmd(rd_cmd), .got(got));
  // array preload: erased flash, open unsecured settings, eeprom words with ecc faults
  initial begin
    for (int i = 0; i < nfc_pkg::FL_BYTES; i++) DUT.flash_mem[i] = nfc_pkg::ERASED_BYTE;
    for (int i = 0; i < nfc_pkg::EE_WORDS; i++) DUT.ee_mem[i] = nfc_pkg::nfc_ecc_enc(16'hffff);
    DUT.flash_mem[nfc_pkg::CFG_FLASH_PROTECT_REG_ADDR] = 8'h80;
    DUT.flash_mem[nfc_pkg::CFG_EEPROM_PROTECT_REG_ADDR] = 8'h80;
    DUT.flash_mem[nfc_pkg::CFG_NVM_OPTION_REG_ADDR] = 8'h00;
    DUT.flash_mem[nfc_pkg::CFG_SECURITY_REG_ADDR] = 8'h02;
    DUT.ee_mem[7'h20] = nfc_pkg::nfc_ecc_enc(16'h1234) ^ 22'h000020;
    DUT.ee_mem[7'h21] = nfc_pkg::nfc_ecc_enc(16'h5678) ^ 22'h000006;
  end
  // apb transfer: setup, access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the flag is back before the next command
  task automatic wait_flag();
    int i;
    i = 0;
    do begin
      apb(1'b0, nfc_pkg::REG_STAT, 32'h0);
      i++;
    end while (q[nfc_pkg::STAT_CMD_COMPLETE_FLAG] !== 1'b1 && i < 1000);
  endtask
  // index then command object word
  task automatic obj(input logic [2:0] i, input logic [15:0] v);
    apb(1'b1, nfc_pkg::REG_IX, {29'h0, i});
    apb(1'b1, nfc_pkg::REG_CCOB, {16'h0, v});
  endtask
  // cpu array read through the partner model, looked at once settled
  task automatic rd(input logic ee, input logic [15:0] a);
    @(posedge ref_clk);
    want <= {ee, a};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic t_init();
    go <= 1'b1;
    apb(1'b1, nfc_pkg::REG_DIV, 32'h0000_0003);
    apb(1'b0, nfc_pkg::REG_DIV, 32'h0);
    `CHK("div locked", 32'h0, q)
    apb(1'b0, nfc_pkg::REG_STAT, 32'h0);
    `CHK("flag in init", 1'b0, q[nfc_pkg::STAT_CMD_COMPLETE_FLAG])
    `CHK("read held", 1'b0, got)
    apb(1'b0, nfc_pkg::REG_FLASH_PROTECT_REG, 32'h0);
    `CHK("protect default", 32'h0, q)
    wait_flag();
    `CHK("flag at end", 1'b1, q[nfc_pkg::STAT_CMD_COMPLETE_FLAG])
    `CHK("reads resumed", 1'b1, got)
    apb(1'b0, nfc_pkg::REG_FLASH_PROTECT_REG, 32'h0);
    `CHK("protect loaded", 32'h80, q)
  endtask
  task automatic t_nodiv();
    apb(1'b1, nfc_pkg::REG_IX, 32'h0);
    apb(1'b1, nfc_pkg::REG_CCOB, {16'h0, nfc_pkg::CMD_ERS_SECT, 8'h00});
    apb(1'b1, nfc_pkg::REG_STAT, 32'h0000_0080);
    apb(1'b0, nfc_pkg::REG_STAT, 32'h0);
    `CHK("access error", 1'b1, q[nfc_pkg::STAT_ACCESS_ERROR_FLAG])
    `CHK("refused done", 1'b1, q[nfc_pkg::STAT_CMD_COMPLETE_FLAG])
    apb(1'b1, nfc_pkg::REG_STAT, 32'h0000_0020);
    apb(1'b0, nfc_pkg::REG_STAT, 32'h0);
    `CHK("error cleared", 1'b0, q[nfc_pkg::STAT_ACCESS_ERROR_FLAG])
    apb(1'b1, nfc_pkg::REG_DIV, 32'h0000_0000);
    apb(1'b0, nfc_pkg::REG_DIV, 32'h0);
    `CHK("div loaded", 1'b1, q[nfc_pkg::DIV_LD])
  endtask
  task automatic t_misc();
    apb(1'b0, 8'hfc, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, nfc_pkg::REG_CFG, 32'h0000_0080);
    stop_req <= 1'b1;
    @(negedge ref_clk);
    `CHK("cmd irq", 1'b1, cmd_irq)
    `CHK("no err irq", 1'b0, err_irq)
    `CHK("stop idle", 1'b1, stop_ack)
  endtask
  // flash program with stop pending and eeprom reads held, then sector erase
  task automatic t_flash();
    obj(3'h0, {nfc_pkg::CMD_PGM_FL, 8'h00});
    want <= {1'b1, 16'h0040};
    obj(3'h1, 16'h4000);
    obj(3'h2, 16'h12ff);
    obj(3'h3, 16'h0f3c);
    apb(1'b1, nfc_pkg::REG_STAT, 32'h0000_0080);
    @(negedge ref_clk);
    `CHK("ee read held", 1'b0, rd_ready)
    `CHK("stop deferred", 1'b0, stop_ack)
    wait_flag();
    @(negedge ref_clk);
    `CHK("stop after op", 1'b1, stop_ack)
    rd(1'b1, 16'h0040);
    `CHK("ee single fix", 10'h04a, rd_data)
    rd(1'b0, 16'h4003);
    `CHK("flash programmed", 8'h3c, rd_data.data)
    obj(3'h0, {nfc_pkg::CMD_ERS_SECT, 8'h00});
    apb(1'b1, nfc_pkg::REG_STAT, 32'h0000_0080);
    wait_flag();
    rd(1'b0, 16'h4003);
    `CHK("flash erased", nfc_pkg::ERASED_BYTE, rd_data.data)
  endtask
  // eeprom burst while flash reads go on, then ecc fault flags
  task automatic t_ee();
    obj(3'h0, {nfc_pkg::CMD_PGM_EE, 8'h00});
    obj(3'h1, 16'h0010);
    obj(3'h2, 16'h005a);
    obj(3'h3, 16'h00c3);
    apb(1'b1, nfc_pkg::REG_STAT, 32'h0000_0080);
    @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("flash read served", 1'b1, rd_ready)
    wait_flag();
    rd(1'b1, 16'h0010);
    `CHK("burst byte 0", 8'h5a, rd_data.data)
    rd(1'b1, 16'h0011);
    `CHK("burst byte 1", 8'hc3, rd_data.data)
    rd(1'b1, 16'h0042);
    `CHK("ee double flag", 1'b1, rd_data.dbl)
    apb(1'b1, nfc_pkg::REG_CFG, 32'h0000_0081);
    apb(1'b0, nfc_pkg::REG_ERR, 32'h0);
    `CHK("fault flags", 32'h3, q)
    `CHK("err irq", 1'b1, err_irq)
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog on the whole run
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_init();
    t_nodiv();
    t_misc();
    t_flash();
    t_ee();
    wrap_up();
  end
endmodule
`default_nettype wire
